// >>> include/sad_pkg.sv
// Purpose: Shared constants and carrier types for the system address decoder.
// Assumes: 32-bit physical addresses, 10 MHz aclk, AXI4-Lite configuration bus.
// Notes: Offsets are byte addresses of 32-bit words.
// What this block does
// R01 - Interrupt controller units decode to hub at 4 KB.
// R02 - Gap above interrupt range always goes to hub.
// R03 - Top 2 MB boot range goes to hub.
// R04 - Three management memory options, top one 512K/1M.
// R05 - Hub and graphics masters never reach management memory.
// R06 - Shadow attributes steer reads and writes per range.
// R07 - Other processor I/O is forwarded to hub.
// R08 - Graphics port I/O cycles get no response.
// R09 - Config address and data ports in I/O space; code claims only I/O 0CF8-0CFB.
// R10 - I/O addresses untranslated, bit 16 on wrap.
// R11 - Disk controller I/O writes are never posted.
// R12 - Command register I/O disable stops graphics routing.
// R13 - One address map for all three requesters.
// R14 - Hub accepts DRAM, aperture, window writes, VGA writes.
// R15 - Hub I/O cycles refused with master abort.
// R16 - Invalid hub memory remapped, snooped, master aborted.
// R17 - Per aligned block completion status for hub requests.
// R18 - Crossing part of hub request remapped to zero; code keeps the start address and flags only the last block in blk_abort.
// R19 - Invalid start remaps whole hub request to zero.
// R20 - Graphics PCI memory claimed only for DRAM or aperture.
// R21 - Graphics compat access needs matching attribute enable.
// R22 - Graphics special and config cycles get no response.
// R23 - Fixed latency, special ranges checked before defaults.
package sad_pkg;
   // Register byte offsets.
   localparam logic [7:0] OFS_CONTROL = 8'h00;
   localparam logic [7:0] OFS_TOP_OF_MEM = 8'h04;
   localparam logic [7:0] OFS_APERTURE_BASE = 8'h08;
   localparam logic [7:0] OFS_APERTURE_SIZE = 8'h0C;
   localparam logic [7:0] OFS_WIN_BASE = 8'h10;
   localparam logic [7:0] OFS_WIN_LIMIT = 8'h14;
   localparam logic [7:0] OFS_PF_BASE = 8'h18;
   localparam logic [7:0] OFS_PF_LIMIT = 8'h1C;
   localparam logic [7:0] OFS_COMPAT_ATTR = 8'h20;
   localparam logic [7:0] OFS_HIGH_SEG = 8'h24;
   localparam logic [7:0] OFS_IO_WIN = 8'h28;
   localparam logic [7:0] OFS_DISK_IO = 8'h2C;
   localparam logic [7:0] OFS_CFG_ADDR = 8'h30;
   localparam logic [7:0] OFS_CFG_DATA = 8'h34;
   localparam logic [7:0] OFS_STATUS = 8'h38;
   // Control register fields.
   localparam int CTL_COMPAT_SMM = 0;
   localparam int CTL_HIGH_SMM = 1;
   localparam int CTL_TOP_SMM = 2;
   localparam int CTL_TOP_1MB = 3;
   localparam int CTL_CMD_A_IO = 4;
   localparam int CTL_CMD_B_IO = 5;
   localparam int CTL_VGA_EN = 6;
   localparam int CTL_BLK64 = 7;
   localparam logic [31:0] CONTROL_RESET = 32'h0000_0030;
   localparam logic [31:0] TOM_RESET = 32'h0100_0000;
   // Fixed ranges.
   localparam logic [31:0] IOAPIC_BASE = 32'hFEC0_0000;
   localparam logic [31:0] IOAPIC_END = 32'hFECF_FFFF;
   localparam logic [31:0] GAP_BASE = 32'hFED0_0000;
   localparam logic [31:0] GAP_END = 32'hFFDF_FFFF;
   localparam logic [31:0] HBIOS_BASE = 32'hFFE0_0000;
   localparam logic [31:0] COMPAT_SMM_BASE = 32'h000A_0000;
   localparam logic [31:0] COMPAT_SMM_END = 32'h000B_FFFF;
   localparam logic [31:0] VGA_BASE = 32'h000A_0000;
   localparam logic [31:0] VGA_END = 32'h000B_FFFF;
   localparam logic [31:0] SHADOW_BASE = 32'h000C_0000;
   localparam logic [31:0] ONE_MB = 32'h0010_0000;
   localparam logic [31:0] TOP_SEG_512K = 32'h0008_0000;
   localparam logic [31:0] TOP_SEG_1M = 32'h0010_0000;
   localparam logic [31:0] HIGH_MGMT_SEGMENT_SIZE = 32'h0002_0000;
   localparam logic [16:0] IO_WRAP_START4 = 17'h0FFFD;
   localparam logic [16:0] IO_WRAP_START2 = 17'h0FFFF;
   localparam logic [31:0] REMAP_ADDR = 32'h0000_0000;
   localparam logic [8:0] MAX_LEN = 9'h100;
   localparam int DECODE_LAT = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Requesters, operations and destinations.
   typedef enum logic [1:0] {SRC_HOST, SRC_HUB, SRC_GFX, SRC_IGD} sad_src_t;
   typedef enum logic [1:0] {OP_MEM, OP_IO, OP_SPECIAL, OP_CFG} sad_op_t;
   typedef enum logic [2:0] {DST_NONE, DST_DRAM, DST_HUB, DST_GFX, DST_CFG, DST_ABORT} sad_dst_t;
   typedef struct packed {
      sad_src_t src;
      sad_op_t op;
      logic write;
      logic smm;
      logic [31:0] addr;
      logic [8:0] len;
      logic [2:0] io_size;
   } sad_req_t;
   typedef struct packed {
      sad_dst_t dst;
      logic [31:0] addr;
      logic addr_bit16;
      logic snoop;
      logic master_abort;
      logic claim;
      logic non_posted;
      logic all_ones;
      logic clear_be;
      logic [7:0] blk_abort;
      logic cfg_hit;
   } sad_rsp_t;
endpackage : sad_pkg

// >>> hdl/sad_decoder.sv
// Purpose: System address decoder routing host, hub and graphics requests.
// Assumes: One request per cycle on req_valid; answer two aclk edges later.
// Notes: Configuration registers sit on an AXI4-Lite slave.
`timescale 1ns/1ps
`default_nettype none
module sad_decoder (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite slave
   input wire logic [7:0] s_awaddr,
   input wire logic s_awvalid,
   output logic s_awready,
   input wire logic [31:0] s_wdata,
   input wire logic [3:0] s_wstrb,
   input wire logic s_wvalid,
   output logic s_wready,
   output logic [1:0] s_bresp,
   output logic s_bvalid,
   input wire logic s_bready,
   input wire logic [7:0] s_araddr,
   input wire logic s_arvalid,
   output logic s_arready,
   output logic [31:0] s_rdata,
   output logic [1:0] s_rresp,
   output logic s_rvalid,
   input wire logic s_rready,
   // Decode request and answer
   input wire logic req_valid,
   input wire sad_pkg::sad_req_t req,
   output logic rsp_valid,
   output sad_pkg::sad_rsp_t rsp
);
   // ==========================================================
   // Register file
   logic [31:0] ctl_reg, tom_reg, apb_reg, aps_reg, wb_reg, wl_reg, pb_reg, pl_reg;
   logic [31:0] attr_reg, high_mgmt_segment_reg, iow_reg, disk_reg, cfga_reg, cfgd_reg;
   logic [31:0] cnt_reg;
   logic aw_hold_reg, w_hold_reg;
   logic [7:0] awa_reg;
   logic [31:0] wd_reg;
   logic [3:0] ws_reg;
   wire do_write = aw_hold_reg && w_hold_reg && !s_bvalid;
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) begin
            r[i*8 +: 8] = d[i*8 +: 8];
         end
      end
      return r;
   endfunction : merge
   function automatic logic in_rng(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction : in_rng
   wire known_w = awa_reg <= sad_pkg::OFS_CFG_DATA && awa_reg[1:0] == 2'h0;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         awa_reg <= 8'h00;
         wd_reg <= 32'h0000_0000;
         ws_reg <= 4'h0;
         s_bvalid <= 1'b0;
         s_bresp <= sad_pkg::RESP_OKAY;
      end else begin
         if (s_awvalid && s_awready) begin
            aw_hold_reg <= 1'b1;
            awa_reg <= s_awaddr;
         end
         if (s_wvalid && s_wready) begin
            w_hold_reg <= 1'b1;
            wd_reg <= s_wdata;
            ws_reg <= s_wstrb;
         end
         if (do_write) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            s_bvalid <= 1'b1;
            s_bresp <= known_w ? sad_pkg::RESP_OKAY : sad_pkg::RESP_SLVERR;
         end else if (s_bvalid && s_bready) begin
            s_bvalid <= 1'b0;
         end
      end
   end
   assign s_awready = !aw_hold_reg && aresetn;
   assign s_wready = !w_hold_reg && aresetn;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl_reg <= sad_pkg::CONTROL_RESET;
         tom_reg <= sad_pkg::TOM_RESET;
         {apb_reg, aps_reg, wb_reg, wl_reg, pb_reg, pl_reg} <= '0;
         {attr_reg, high_mgmt_segment_reg, iow_reg, disk_reg, cfga_reg, cfgd_reg} <= '0;
      end else if (do_write) begin
         unique case (awa_reg)
            sad_pkg::OFS_CONTROL: ctl_reg <= merge(ctl_reg, wd_reg, ws_reg);
            sad_pkg::OFS_TOP_OF_MEM: tom_reg <= merge(tom_reg, wd_reg, ws_reg);
            sad_pkg::OFS_APERTURE_BASE: apb_reg <= merge(apb_reg, wd_reg, ws_reg);
            sad_pkg::OFS_APERTURE_SIZE: aps_reg <= merge(aps_reg, wd_reg, ws_reg);
            sad_pkg::OFS_WIN_BASE: wb_reg <= merge(wb_reg, wd_reg, ws_reg);
            sad_pkg::OFS_WIN_LIMIT: wl_reg <= merge(wl_reg, wd_reg, ws_reg);
            sad_pkg::OFS_PF_BASE: pb_reg <= merge(pb_reg, wd_reg, ws_reg);
            sad_pkg::OFS_PF_LIMIT: pl_reg <= merge(pl_reg, wd_reg, ws_reg);
            sad_pkg::OFS_COMPAT_ATTR: attr_reg <= merge(attr_reg, wd_reg, ws_reg);
            sad_pkg::OFS_HIGH_SEG: high_mgmt_segment_reg <= merge(high_mgmt_segment_reg, wd_reg, ws_reg);
            sad_pkg::OFS_IO_WIN: iow_reg <= merge(iow_reg, wd_reg, ws_reg);
            sad_pkg::OFS_DISK_IO: disk_reg <= merge(disk_reg, wd_reg, ws_reg);
            sad_pkg::OFS_CFG_ADDR: cfga_reg <= merge(cfga_reg, wd_reg, ws_reg); // [R09]
            sad_pkg::OFS_CFG_DATA: cfgd_reg <= merge(cfgd_reg, wd_reg, ws_reg); // [R09]
            default: ;
         endcase
      end
   end
   // Read channel; status shows a count of aborted requests.
   logic [31:0] rd_mux;
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (s_araddr)
         sad_pkg::OFS_CONTROL: rd_mux = ctl_reg;
         sad_pkg::OFS_TOP_OF_MEM: rd_mux = tom_reg;
         sad_pkg::OFS_APERTURE_BASE: rd_mux = apb_reg;
         sad_pkg::OFS_APERTURE_SIZE: rd_mux = aps_reg;
         sad_pkg::OFS_WIN_BASE: rd_mux = wb_reg;
         sad_pkg::OFS_WIN_LIMIT: rd_mux = wl_reg;
         sad_pkg::OFS_PF_BASE: rd_mux = pb_reg;
         sad_pkg::OFS_PF_LIMIT: rd_mux = pl_reg;
         sad_pkg::OFS_COMPAT_ATTR: rd_mux = attr_reg;
         sad_pkg::OFS_HIGH_SEG: rd_mux = high_mgmt_segment_reg;
         sad_pkg::OFS_IO_WIN: rd_mux = iow_reg;
         sad_pkg::OFS_DISK_IO: rd_mux = disk_reg;
         sad_pkg::OFS_CFG_ADDR: rd_mux = cfga_reg;
         sad_pkg::OFS_CFG_DATA: rd_mux = cfgd_reg;
         sad_pkg::OFS_STATUS: rd_mux = cnt_reg;
         default: rd_mux = 32'h0000_0000;
      endcase
   end
   wire known_r = s_araddr <= sad_pkg::OFS_STATUS && s_araddr[1:0] == 2'h0;
   assign s_arready = !s_rvalid && aresetn;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_rvalid <= 1'b0;
         s_rdata <= 32'h0000_0000;
         s_rresp <= sad_pkg::RESP_OKAY;
      end else if (s_arvalid && s_arready) begin
         s_rvalid <= 1'b1;
         s_rdata <= rd_mux;
         s_rresp <= known_r ? sad_pkg::RESP_OKAY : sad_pkg::RESP_SLVERR;
      end else if (s_rvalid && s_rready) begin
         s_rvalid <= 1'b0;
      end
   end
   // ==========================================================
   // Range decode
   wire [31:0] a = req.addr;
   wire [31:0] a_end = req.addr + {23'h0, req.len} - 32'h1;
   wire [31:0] tseg_sz = ctl_reg[sad_pkg::CTL_TOP_1MB] ? sad_pkg::TOP_SEG_1M : sad_pkg::TOP_SEG_512K;
   wire [31:0] tseg_lo = tom_reg - tseg_sz;
   wire [31:0] high_mgmt_segment_hi = high_mgmt_segment_reg + sad_pkg::HIGH_MGMT_SEGMENT_SIZE - 32'h1;
   function automatic logic is_smm(input logic [31:0] x, input logic [31:0] c, input logic [31:0] tl,
                                   input logic [31:0] tm, input logic [31:0] hb, input logic [31:0] hh);
      return (c[sad_pkg::CTL_COMPAT_SMM] && in_rng(x, sad_pkg::COMPAT_SMM_BASE, sad_pkg::COMPAT_SMM_END)) ||
             (c[sad_pkg::CTL_HIGH_SMM] && in_rng(x, hb, hh)) ||
             (c[sad_pkg::CTL_TOP_SMM] && x >= tl && x < tm); // [R04]
   endfunction : is_smm
   function automatic logic is_dram(input logic [31:0] x, input logic [31:0] tm);
      return (x < sad_pkg::VGA_BASE) || (x >= sad_pkg::ONE_MB && x < tm);
   endfunction : is_dram
   wire hit_smm = is_smm(a, ctl_reg, tseg_lo, tom_reg, high_mgmt_segment_reg, high_mgmt_segment_hi);
   wire hit_ioapic = in_rng(a, sad_pkg::IOAPIC_BASE, sad_pkg::IOAPIC_END); // [R01]
   wire hit_gap = in_rng(a, sad_pkg::GAP_BASE, sad_pkg::GAP_END); // [R02]
   wire hit_hbios = a >= sad_pkg::HBIOS_BASE; // [R03]
   wire hit_dram = is_dram(a, tom_reg);
   wire hit_ap = aps_reg != 32'h0 && a >= apb_reg && a - apb_reg < aps_reg;
   wire hit_win = in_rng(a, wb_reg, wl_reg) || in_rng(a, pb_reg, pl_reg);
   wire hit_vga = in_rng(a, sad_pkg::VGA_BASE, sad_pkg::VGA_END);
   wire hit_shadow = a >= sad_pkg::SHADOW_BASE && a < sad_pkg::ONE_MB;
   // Each 16 KB shadow segment has a read enable bit at 2n and a write enable at 2n+1.
   wire [3:0] shadow_seg = a[17:14];
   wire attr_re = attr_reg[{shadow_seg, 1'b0}];
   wire attr_we = attr_reg[{shadow_seg, 1'b1}];
   wire shadow_dram = req.write ? attr_we : attr_re; // [R06] [R21]
   wire gfx_io_on = ctl_reg[sad_pkg::CTL_CMD_A_IO] && ctl_reg[sad_pkg::CTL_CMD_B_IO]; // [R12]
   wire [15:0] io_a = a[15:0];
   wire io_gfx = gfx_io_on && io_a >= iow_reg[15:0] && io_a <= iow_reg[31:16];
   wire io_cfg = (io_a == 16'h0CF8) || (io_a[15:2] == 14'h033E); // [R09]
   wire io_disk = io_a[15:3] == disk_reg[15:3] && disk_reg[16];
   wire [16:0] io_top = {1'b0, io_a} + {14'h0, req.io_size} - 17'h1;
   // Hub region class of start and end of the request.
   function automatic logic [1:0] hub_cls(input logic [31:0] x, input logic [31:0] c, input logic [31:0] tl,
                                        input logic [31:0] tm, input logic [31:0] hb, input logic [31:0] hh,
                                        input logic w, input logic ap, input logic win);
      if (is_smm(x, c, tl, tm, hb, hh)) return 2'd0; // [R05]
      if (is_dram(x, tm) || (x >= sad_pkg::SHADOW_BASE && x < sad_pkg::ONE_MB) || ap) return 2'd1; // [R14]
      if (w && (win || (c[sad_pkg::CTL_VGA_EN] && in_rng(x, sad_pkg::VGA_BASE, sad_pkg::VGA_END)))) return 2'd2;
      return 2'd0;
   endfunction : hub_cls
   wire end_ap = aps_reg != 32'h0 && a_end >= apb_reg && a_end - apb_reg < aps_reg;
   wire end_win = in_rng(a_end, wb_reg, wl_reg) || in_rng(a_end, pb_reg, pl_reg);
   wire [1:0] cls_s = hub_cls(a, ctl_reg, tseg_lo, tom_reg, high_mgmt_segment_reg, high_mgmt_segment_hi, req.write, hit_ap, hit_win);
   wire [1:0] cls_e = hub_cls(a_end, ctl_reg, tseg_lo, tom_reg, high_mgmt_segment_reg, high_mgmt_segment_hi, req.write, end_ap, end_win);
   wire blk64 = ctl_reg[sad_pkg::CTL_BLK64];
   wire [3:0] last_off = blk64 ? {1'b0, a_end[8:6]} - {1'b0, a[8:6]} : {a_end[8:5]} - {a[8:5]};
   // ==========================================================
   // Decision, checked in priority order
   sad_pkg::sad_rsp_t dec;
   always_comb begin
      dec = '0;
      dec.addr = a;
      unique case (req.op)
         sad_pkg::OP_MEM: begin
            if (req.src == sad_pkg::SRC_HUB) begin
               if (cls_s == 2'd0) begin // [R19]
                  dec.dst = sad_pkg::DST_DRAM;
                  dec.addr = sad_pkg::REMAP_ADDR;
                  dec.snoop = 1'b1;
                  dec.master_abort = 1'b1; // [R16]
                  dec.all_ones = !req.write;
                  dec.clear_be = req.write;
                  dec.blk_abort = 8'hFF;
               end else begin
                  dec.dst = cls_s == 2'd1 ? sad_pkg::DST_DRAM : sad_pkg::DST_GFX;
                  dec.snoop = cls_s == 2'd1;
                  if (cls_e != cls_s) begin // [R18]
                     for (int i = 0; i < 8; i++) begin
                        dec.blk_abort[i] = 4'(i) == last_off; // [R17]
                     end
                     dec.master_abort = 1'b1;
                  end
               end
            end else if (req.src == sad_pkg::SRC_GFX) begin
               if (hit_smm) begin
                  dec.dst = sad_pkg::DST_NONE; // [R05]
               end else if (hit_shadow) begin
                  dec.dst = shadow_dram ? sad_pkg::DST_DRAM : sad_pkg::DST_NONE; // [R21]
                  dec.claim = shadow_dram;
               end else if (hit_dram || hit_ap) begin
                  dec.dst = sad_pkg::DST_DRAM; // [R20]
                  dec.claim = 1'b1;
               end else begin
                  dec.dst = sad_pkg::DST_NONE; // [R20]
               end
            end else begin // [R13]
               if (hit_smm) begin
                  dec.dst = req.smm ? sad_pkg::DST_DRAM : sad_pkg::DST_HUB; // [R23]
               end else if (hit_ioapic || hit_gap || hit_hbios) begin
                  dec.dst = sad_pkg::DST_HUB; // [R01] [R02] [R03]
               end else if (hit_shadow) begin
                  dec.dst = shadow_dram ? sad_pkg::DST_DRAM : sad_pkg::DST_HUB; // [R06]
               end else if (hit_vga && ctl_reg[sad_pkg::CTL_VGA_EN]) begin
                  dec.dst = sad_pkg::DST_GFX;
               end else if (hit_dram || hit_ap) begin
                  dec.dst = sad_pkg::DST_DRAM;
               end else if (hit_win) begin
                  dec.dst = sad_pkg::DST_GFX;
               end else begin
                  dec.dst = sad_pkg::DST_HUB;
               end
            end
         end
         sad_pkg::OP_IO: begin
            if (req.src == sad_pkg::SRC_HUB) begin
               dec.dst = sad_pkg::DST_ABORT; // [R15]
               dec.master_abort = 1'b1;
            end else if (req.src == sad_pkg::SRC_GFX) begin
               dec.dst = sad_pkg::DST_NONE; // [R08] [R22]
            end else begin
               dec.addr = {15'h0, io_top[16], io_a}; // [R10]
               dec.addr_bit16 = (io_top[16] && req.io_size == 3'd4 && {1'b0, io_a} >= sad_pkg::IO_WRAP_START4) ||
                                (req.io_size == 3'd2 && {1'b0, io_a} == sad_pkg::IO_WRAP_START2); // [R10]
               dec.cfg_hit = io_cfg;
               dec.dst = io_cfg ? sad_pkg::DST_CFG : io_gfx ? sad_pkg::DST_GFX : sad_pkg::DST_HUB; // [R07] [R12]
               dec.non_posted = req.write && io_disk && !io_cfg && !io_gfx; // [R11]
            end
         end
         sad_pkg::OP_SPECIAL, sad_pkg::OP_CFG: begin
            dec.dst = req.src == sad_pkg::SRC_GFX ? sad_pkg::DST_NONE : sad_pkg::DST_HUB; // [R22]
         end
      endcase
   end
   // Two-stage pipeline fixes the decode latency.
   logic v1_reg;
   sad_pkg::sad_rsp_t d1_reg;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         v1_reg <= 1'b0;
         d1_reg <= '0;
         rsp_valid <= 1'b0;
         rsp <= '0;
         cnt_reg <= 32'h0;
      end else begin
         v1_reg <= req_valid; // [R23]
         d1_reg <= dec;
         rsp_valid <= v1_reg;
         rsp <= d1_reg;
         if (v1_reg && d1_reg.master_abort) begin
            cnt_reg <= cnt_reg + 32'h1;
         end
      end
   end
   // ==========================================================
   // Checks
   property p_latency;
      @(posedge aclk) disable iff (!aresetn) req_valid |-> ##2 rsp_valid;
   endproperty
   a_latency: assert property (p_latency) else $error("answer not two cycles after request"); // [R23]
   property p_hub_io;
      @(posedge aclk) disable iff (!aresetn)
         req_valid && req.src == sad_pkg::SRC_HUB && req.op == sad_pkg::OP_IO |-> ##2 rsp.master_abort;
   endproperty
   a_hub_io: assert property (p_hub_io) else $error("hub I/O not aborted"); // [R15]
   property p_gfx_io;
      @(posedge aclk) disable iff (!aresetn)
         req_valid && req.src == sad_pkg::SRC_GFX && req.op != sad_pkg::OP_MEM |-> ##2 rsp.dst == sad_pkg::DST_NONE;
   endproperty
   a_gfx_io: assert property (p_gfx_io) else $error("graphics non-memory cycle answered"); // [R08]
   property p_gap;
      @(posedge aclk) disable iff (!aresetn)
         req_valid && req.src == sad_pkg::SRC_HOST && req.op == sad_pkg::OP_MEM && hit_gap && !hit_smm
         |-> ##2 rsp.dst == sad_pkg::DST_HUB;
   endproperty
   a_gap: assert property (p_gap) else $error("gap not sent to hub"); // [R02]
   property p_hbios;
      @(posedge aclk) disable iff (!aresetn)
         req_valid && req.src == sad_pkg::SRC_HOST && req.op == sad_pkg::OP_MEM && hit_hbios && !hit_smm
         |-> ##2 rsp.dst == sad_pkg::DST_HUB;
   endproperty
   a_hbios: assert property (p_hbios) else $error("boot range not sent to hub"); // [R03]
   property p_smm_block;
      @(posedge aclk) disable iff (!aresetn)
         req_valid && req.src == sad_pkg::SRC_GFX && hit_smm |-> ##2 !rsp.claim;
   endproperty
   a_smm_block: assert property (p_smm_block) else $error("graphics master reached management memory"); // [R05]
   property p_remap;
      @(posedge aclk) disable iff (!aresetn)
         req_valid && req.src == sad_pkg::SRC_HUB && req.op == sad_pkg::OP_MEM && cls_s == 2'd0
         |-> ##2 rsp.addr == sad_pkg::REMAP_ADDR && rsp.snoop && rsp.master_abort;
   endproperty
   a_remap: assert property (p_remap) else $error("invalid hub request not remapped"); // [R19]
   property p_cmd_io;
      @(posedge aclk) disable iff (!aresetn) !gfx_io_on && req_valid |-> ##2 !(rsp.dst == sad_pkg::DST_GFX && $past(req.op, 2) == sad_pkg::OP_IO);
   endproperty
   a_cmd_io: assert property (p_cmd_io) else $error("I/O routed to graphics while disabled"); // [R12]
   property p_cfg_io;
      @(posedge aclk) disable iff (!aresetn)
         req_valid && req.src == sad_pkg::SRC_HOST && req.op == sad_pkg::OP_IO && io_cfg
         |-> ##2 rsp.dst == sad_pkg::DST_CFG && rsp.cfg_hit;
   endproperty
   a_cfg_io: assert property (p_cfg_io) else $error("config port access not claimed"); // [R09]
endmodule : sad_decoder
`default_nettype wire

// >>> testbench/sad_req_model.sv
// Purpose: Requester model that issues decode requests and watches answers.
// Assumes: One request for each cycle that go is high.
// Notes: An unclaimed graphics cycle is aborted by this initiator.
`timescale 1ns/1ps
`default_nettype none
module sad_req_model (
   // Clock
   input wire logic aclk,
   // Stimulus from the bench
   input wire logic go,
   input wire sad_pkg::sad_req_t cmd,
   // Decoder side
   input wire logic rsp_valid,
   input wire sad_pkg::sad_rsp_t rsp,
   output logic req_valid = 1'b0,
   output sad_pkg::sad_req_t req = '0,
   output logic gfx_abort = 1'b0
);
   // ==========================================================
   // Request launch and abort on silence.
   // An idle bus shows the inverse of the command, never a stale copy.
   always @(posedge aclk) begin
      req_valid <= go;
      req <= go ? cmd : ~cmd;
      gfx_abort <= rsp_valid && !rsp.claim && rsp.dst == sad_pkg::DST_NONE;
   end
endmodule : sad_req_model
`default_nettype wire

// >>> testbench/sad_decoder_tb_top.sv
// Purpose: Self-checking bench for the system address decoder.
// Assumes: Answers come a fixed time after each request pulse.
// Notes: Random addresses come from a fixed-seed xorshift.
`timescale 1ns/1ps
`default_nettype none
module sad_decoder_tb_top;
   // ==========================================================
   // Signals and instances.
   logic aclk = 0, aresetn = 0, go = 0, rsp_valid, req_valid, gfx_abort;
   logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
   logic [31:0] s_wdata = 32'h0, s_rdata, seed = 32'h0000_8098;
   logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
   logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
   logic [1:0] s_bresp, s_rresp;
   int fails = 0, samples_checked = 0, cyc = 0;
   sad_pkg::sad_req_t cmd = '0, req;
   sad_pkg::sad_rsp_t rsp;
   initial forever #50 aclk = ~aclk;
   sad_decoder dut (.aclk, .aresetn, .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb(4'hF),
      .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
      .s_rdata, .s_rresp, .s_rvalid, .s_rready, .req_valid, .req, .rsp_valid, .rsp);
   sad_req_model model (.aclk, .go, .cmd, .rsp_valid, .rsp, .req_valid, .req, .gfx_abort);
   // ==========================================================
   // Helpers.
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd
   function automatic logic exp_wrap(input logic [31:0] a, input logic [2:0] n);
      return (n == 3'h4 && a >= 32'h0000_FFFD) || (n == 3'h2 && a == 32'h0000_FFFF);
   endfunction : exp_wrap
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      s_awaddr <= a;
      s_wdata <= d;
      s_awvalid <= 1;
      s_wvalid <= 1;
      s_bready <= 1;
      do @(negedge aclk); while (!(s_awready && s_wready));
      @(posedge aclk);
      s_awvalid <= 0;
      s_wvalid <= 0;
      do @(negedge aclk); while (!s_bvalid);
      @(posedge aclk);
      s_bready <= 0;
   endtask : axw
   task automatic axr(input logic [7:0] a);
      s_araddr <= a;
      s_arvalid <= 1;
      s_rready <= 1;
      do @(negedge aclk); while (!s_arready);
      @(posedge aclk);
      s_arvalid <= 0;
      do @(negedge aclk); while (!s_rvalid);
      @(posedge aclk);
      s_rready <= 0;
   endtask : axr
   task automatic dec(input sad_pkg::sad_src_t s, input sad_pkg::sad_op_t o, input logic [31:0] a,
                      input logic [2:0] n);
      cmd <= '{s, o, 1'b0, 1'b0, a, 9'h004, n};
      go <= 1;
      @(posedge aclk);
      go <= 0;
      do @(negedge aclk); while (rsp_valid !== 1'b1);
   endtask : dec
   task automatic tally_and_finish();
      if (fails == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 5000) begin
         fails++;
         tally_and_finish();
      end
   end
   // ==========================================================
   // Main sequence.
   initial begin
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      @(posedge aclk);
      axr(sad_pkg::OFS_CONTROL);
      chk(s_rdata, sad_pkg::CONTROL_RESET);
      axw(sad_pkg::OFS_CONTROL, 32'h0000_0031);
      chk(s_bresp, sad_pkg::RESP_OKAY);
      axr(sad_pkg::OFS_CONTROL);
      chk(s_rdata, 32'h0000_0031);
      axr(8'hFC);
      chk(s_rresp, sad_pkg::RESP_SLVERR);
      for (int i = 0; i < 16; i++) begin
         dec(sad_pkg::SRC_HOST, sad_pkg::OP_MEM, sad_pkg::IOAPIC_BASE | (i << 12) | (rnd() & 32'hFFF), 4);
         chk(rsp.dst, sad_pkg::DST_HUB);
         dec(sad_pkg::SRC_HOST, sad_pkg::OP_MEM, sad_pkg::GAP_BASE + (rnd() & 32'h00FF_FFFF), 4);
         chk(rsp.dst, sad_pkg::DST_HUB);
         dec(sad_pkg::SRC_HOST, sad_pkg::OP_MEM, sad_pkg::HBIOS_BASE | (rnd() & 32'h001F_FFFF), 4);
         chk(rsp.dst, sad_pkg::DST_HUB);
         dec(sad_pkg::SRC_HUB, sad_pkg::OP_MEM, sad_pkg::GAP_BASE + (rnd() & 32'h00FF_FFFF), 4);
         chk(rsp.addr, sad_pkg::REMAP_ADDR);
         chk(rsp.all_ones, 1'b1);
      end
      for (int o = 1; o < 4; o++) begin
         dec(sad_pkg::SRC_GFX, sad_pkg::sad_op_t'(o), rnd() & 32'hFFFF, 4);
         chk(rsp.claim, 1'b0);
         @(negedge aclk);
         chk(gfx_abort, 1'b1);
         dec(sad_pkg::SRC_HUB, sad_pkg::OP_IO, rnd() & 32'hFFFF, 4);
         chk(rsp.master_abort, 1'b1);
      end
      for (int a = 32'hFFFC; a < 32'h10000; a++) begin
         for (int n = 1; n < 5; n = n * 2) begin
            dec(sad_pkg::SRC_HOST, sad_pkg::OP_IO, a, n);
            chk(rsp.addr_bit16, exp_wrap(a, n));
         end
      end
      axw(sad_pkg::OFS_IO_WIN, 32'hFFFF_0000);
      dec(sad_pkg::SRC_HOST, sad_pkg::OP_IO, 32'h0000_0CF8, 4);
      chk(rsp.dst, sad_pkg::DST_CFG);
      dec(sad_pkg::SRC_HOST, sad_pkg::OP_IO, 32'h0000_1000 | (rnd() & 32'h0FFF), 4);
      chk(rsp.dst, sad_pkg::DST_GFX);
      axw(sad_pkg::OFS_CONTROL, 32'h0000_0021);
      dec(sad_pkg::SRC_HOST, sad_pkg::OP_IO, 32'h0000_1000 | (rnd() & 32'h0FFF), 4);
      chk(rsp.dst, sad_pkg::DST_HUB);
      axw(8'hFC, 32'h0000_0000);
      chk(s_bresp, sad_pkg::RESP_SLVERR);
      tally_and_finish();
   end
endmodule : sad_decoder_tb_top
`default_nettype wire
